// [core/clf_defs.svh]
// Purpose: offsets, reset values and field positions of the driver configuration bank
// Assumes: byte-wide register port, one register per address
// Notes:   definitions only
`ifndef CLF_DEFS_SVH
`define CLF_DEFS_SVH

`define CLF_ADDR_POLARITY    8'h03
`define CLF_ADDR_OUT0_AMP    8'h04
`define CLF_ADDR_OUT0_CTRL   8'h05
`define CLF_ADDR_OUT1_AMP    8'h06
`define CLF_ADDR_OUT1_CTRL   8'h07

`define CLF_RST_POLARITY     8'hc0
`define CLF_RST_OUT0_AMP     8'h90
`define CLF_RST_OUT0_CTRL    8'h02
`define CLF_RST_OUT1_AMP     8'h90
`define CLF_RST_OUT1_CTRL    8'hda
`define CLF_RDATA_NONE       8'h00

// polarity register fields
`define CLF_POL_FAST0_LSB    7
`define CLF_POL_SLOW0_LSB    6
`define CLF_POL_TF_HI        4
`define CLF_POL_TF_LO        1
`define CLF_POL_STATUS       0
// amplitude register fields
`define CLF_AMP_THR_HI       7
`define CLF_AMP_THR_LO       5
`define CLF_AMP_SWING_HI     4
`define CLF_AMP_SWING_LO     0
// output 0 control fields
`define CLF_C0_FORCE_ABSENT  6
`define CLF_C0_FORCE_PRESENT 5
`define CLF_C0_ABSENCE_PD    4
`define CLF_C0_MUTE_SELECT   3
// shared low-rate threshold field and output 1 lsb positions
`define CLF_SLOW_THR_HI      2
`define CLF_SLOW_THR_LO      0
`define CLF_C1_FAST1_LSB     7
`define CLF_C1_SLOW1_LSB     6

`endif

// [core/clf_pkg.sv]
// Purpose: types shared by the driver configuration bank
// Assumes: clf_defs.svh holds the numbers
// Notes:   none
`default_nettype none
package clf_pkg;

    typedef struct packed {
        logic [3:0] term_fault;    // {out1_neg, out1_pos, out0_neg, out0_pos}
        logic       signal_present;
    } clf_detect_type;

    typedef struct packed {
        logic [3:0] term_fault;
        logic       signal_status;
    } clf_mask_type;

    typedef struct packed {
        logic       mute;
        logic       offset;
        logic [1:0] power_down;
    } clf_drive_type;

    typedef struct packed {
        logic [3:0] out0;
        logic [3:0] out1;
    } clf_thresh_type;

endpackage
`default_nettype wire

// [core/clf_fault_merge.sv]
// Purpose: combine detector flags, polarities and masks into the active-low fault pin
// Assumes: all inputs synchronous to clock
// Notes:   one cycle of latency so the pin comes from a flop
`timescale 1ns/10ps
`default_nettype none
module clf_fault_merge (
    input  wire logic                  clock,      // system clock
    input  wire logic                  resetn,     // async reset, low
    input  wire clf_pkg::clf_detect_type detect,   // detector flags
    input  wire clf_pkg::clf_mask_type   mask,     // 1 ignores a source
    input  wire logic [3:0]            tf_polarity,// per-flag trigger polarity
    input  wire logic                  status_pol, // signal-status polarity
    output var  logic                  fault_n     // low while any source fires
);
    import clf_pkg::*;

    logic [3:0] tf_hit;
    logic       status_hit;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_tf
            // polarity 0 fires on flag 1, polarity 1 fires on flag 0
            assign tf_hit[i] = ~mask.term_fault[i] & (detect.term_fault[i] ^ tf_polarity[i]);
        end
    endgenerate

    assign status_hit = ~mask.signal_status & (detect.signal_present == status_pol);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fault_n <= 1'b1;
        end else begin
            fault_n <= ~(|tf_hit | status_hit);
        end
    end
endmodule // clf_fault_merge
`default_nettype wire

// [core/clf_config_bank.sv]
// Purpose: configuration bank 03h..07h of a dual-output cable driver
// Assumes: byte register port from the management bus engine; detectors synchronous
// Notes:   all outputs registered, one cycle after the cause
`timescale 1ns/10ps
`default_nettype none
`include "clf_defs.svh"
module clf_config_bank (
    input  wire logic                  clock,           // 100 MHz clock
    input  wire logic                  resetn,          // async reset, low
    input  wire logic [7:0]            reg_addr,        // register address
    input  wire logic                  reg_write,       // write strobe, one cycle
    input  wire logic [7:0]            reg_wdata,       // write data
    input  wire logic                  reg_read,        // read strobe, one cycle
    output var  logic [7:0]            reg_rdata,       // read data, next cycle
    input  wire clf_pkg::clf_detect_type detect,        // detector flags
    input  wire clf_pkg::clf_mask_type   mask,          // mask bits, 1 ignores
    input  wire logic                  low_rate_select, // rate bit, 1 slow
    input  wire logic                  rate_pin_high,   // rate pin tied high
    input  wire logic                  enable_pin,      // driver enable pin
    input  wire logic                  out0_power_down, // pd bit output 0
    input  wire logic                  out1_power_down, // pd bit output 1
    output var  logic                  fault_n,         // fault pin, low active
    output var  clf_pkg::clf_thresh_type term_thresh,   // active thresholds
    output var  logic [4:0]            out0_swing_code, // output 0 amplitude
    output var  logic [4:0]            out1_swing_code, // output 1 amplitude
    output var  clf_pkg::clf_drive_type  drive,         // mute, offset, power-down
    output var  logic                  slow_rate_active // selected edge rate
);
    import clf_pkg::*;

    logic [7:0] fault_polarity_cfg_reg;
    logic [7:0] out0_threshold_amplitude_reg;
    logic [7:0] out0_signal_loss_ctrl_reg;
    logic [7:0] out1_threshold_amplitude_reg;
    logic [7:0] out1_threshold_ctrl_reg;
    logic [7:0] reg_rdata_next;

    logic           slow_next;
    clf_thresh_type fast_thresh;
    clf_thresh_type slow_thresh;
    logic           force_signal_absent;
    logic           force_signal_present;
    logic           absence_power_down_enable;
    logic           mute_select;
    logic           loss_effect;
    clf_drive_type  drive_next;
    logic [1:0]     pd_bit;
    logic [1:0]     pd_next;

    // reserved bits are stored as written; the host keeps them at their documented values
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fault_polarity_cfg_reg <= `CLF_RST_POLARITY;
        end else if (reg_write && (reg_addr == `CLF_ADDR_POLARITY)) begin
            fault_polarity_cfg_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out0_threshold_amplitude_reg <= `CLF_RST_OUT0_AMP;
        end else if (reg_write && (reg_addr == `CLF_ADDR_OUT0_AMP)) begin
            out0_threshold_amplitude_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out0_signal_loss_ctrl_reg <= `CLF_RST_OUT0_CTRL;
        end else if (reg_write && (reg_addr == `CLF_ADDR_OUT0_CTRL)) begin
            out0_signal_loss_ctrl_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out1_threshold_amplitude_reg <= `CLF_RST_OUT1_AMP;
        end else if (reg_write && (reg_addr == `CLF_ADDR_OUT1_AMP)) begin
            out1_threshold_amplitude_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out1_threshold_ctrl_reg <= `CLF_RST_OUT1_CTRL;
        end else if (reg_write && (reg_addr == `CLF_ADDR_OUT1_CTRL)) begin
            out1_threshold_ctrl_reg <= reg_wdata;
        end
    end

    always_comb begin
        case (reg_addr)
            `CLF_ADDR_POLARITY:  reg_rdata_next = fault_polarity_cfg_reg;
            `CLF_ADDR_OUT0_AMP:  reg_rdata_next = out0_threshold_amplitude_reg;
            `CLF_ADDR_OUT0_CTRL: reg_rdata_next = out0_signal_loss_ctrl_reg;
            `CLF_ADDR_OUT1_AMP:  reg_rdata_next = out1_threshold_amplitude_reg;
            `CLF_ADDR_OUT1_CTRL: reg_rdata_next = out1_threshold_ctrl_reg;
            default:             reg_rdata_next = `CLF_RDATA_NONE;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `CLF_RDATA_NONE;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_next;
        end
    end

    // threshold assembly
    assign slow_next = rate_pin_high | low_rate_select;
    assign fast_thresh.out0 = {out0_threshold_amplitude_reg[`CLF_AMP_THR_HI:`CLF_AMP_THR_LO],
                               fault_polarity_cfg_reg[`CLF_POL_FAST0_LSB]};
    assign slow_thresh.out0 = {out0_signal_loss_ctrl_reg[`CLF_SLOW_THR_HI:`CLF_SLOW_THR_LO],
                               fault_polarity_cfg_reg[`CLF_POL_SLOW0_LSB]};
    assign fast_thresh.out1 = {out1_threshold_amplitude_reg[`CLF_AMP_THR_HI:`CLF_AMP_THR_LO],
                               out1_threshold_ctrl_reg[`CLF_C1_FAST1_LSB]};
    assign slow_thresh.out1 = {out1_threshold_ctrl_reg[`CLF_SLOW_THR_HI:`CLF_SLOW_THR_LO],
                               out1_threshold_ctrl_reg[`CLF_C1_SLOW1_LSB]};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            slow_rate_active <= 1'b0;
        end else begin
            slow_rate_active <= slow_next;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            term_thresh <= '0;
        end else begin
            term_thresh <= slow_next ? slow_thresh : fast_thresh;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out0_swing_code <= '0;
        end else begin
            out0_swing_code <= out0_threshold_amplitude_reg[`CLF_AMP_SWING_HI:`CLF_AMP_SWING_LO];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out1_swing_code <= '0;
        end else begin
            out1_swing_code <= out1_threshold_amplitude_reg[`CLF_AMP_SWING_HI:`CLF_AMP_SWING_LO];
        end
    end

    // signal-loss handling; the status bit itself is never altered by the forces
    assign force_signal_absent       = out0_signal_loss_ctrl_reg[`CLF_C0_FORCE_ABSENT];
    assign force_signal_present      = out0_signal_loss_ctrl_reg[`CLF_C0_FORCE_PRESENT];
    assign absence_power_down_enable = out0_signal_loss_ctrl_reg[`CLF_C0_ABSENCE_PD];
    assign mute_select               = out0_signal_loss_ctrl_reg[`CLF_C0_MUTE_SELECT];

    always_comb begin
        if (force_signal_present) begin
            loss_effect = 1'b0;
        end else if (force_signal_absent) begin
            loss_effect = 1'b1;
        end else begin
            loss_effect = ~detect.signal_present;
        end
        drive_next.mute   = loss_effect & mute_select;
        drive_next.offset = loss_effect & ~mute_select;
        drive_next.power_down = pd_next;
    end

    assign pd_bit = {out1_power_down, out0_power_down};

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_pd
            // a low enable pin always wins; absence joins in only when enabled
            assign pd_next[k] = ~enable_pin | pd_bit[k]
                                | (absence_power_down_enable & ~detect.signal_present);
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            drive <= '0;
        end else begin
            drive <= drive_next;
        end
    end

    clf_fault_merge u_fault_merge (
        .clock       (clock),
        .resetn      (resetn),
        .detect      (detect),
        .mask        (mask),
        .tf_polarity (fault_polarity_cfg_reg[`CLF_POL_TF_HI:`CLF_POL_TF_LO]),
        .status_pol  (fault_polarity_cfg_reg[`CLF_POL_STATUS]),
        .fault_n     (fault_n)
    );
endmodule // clf_config_bank
`default_nettype wire

// [testbench/clf_cfg_monitor.sv]
// Purpose: concurrent checks on the configuration bank ports
// Assumes: outputs follow their causes by one clock
// Notes:   shadows polarity register 03h and control register 05h to know polarity, mute and force settings
`timescale 1ns/10ps
`default_nettype none
`include "clf_defs.svh"
module clf_cfg_monitor (
    input wire logic                    clock,            // clock
    input wire logic                    resetn,           // reset
    input wire logic [7:0]              reg_addr,         // address
    input wire logic                    reg_write,        // write
    input wire logic [7:0]              reg_wdata,        // data
    input wire clf_pkg::clf_detect_type detect,           // flags
    input wire clf_pkg::clf_mask_type   mask,             // masks
    input wire logic                    low_rate_select,  // rate bit
    input wire logic                    rate_pin_high,    // rate pin
    input wire logic                    enable_pin,       // enable
    input wire logic                    out0_power_down,  // pd 0
    input wire logic                    out1_power_down,  // pd 1
    input wire logic                    fault_n,          // fault pin
    input wire clf_pkg::clf_drive_type  drive,            // drive
    input wire logic                    slow_rate_active  // rate
);
    logic [7:0] c0_reg;
    logic [7:0] pol_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) c0_reg <= `CLF_RST_OUT0_CTRL;
        else if (reg_write && reg_addr == `CLF_ADDR_OUT0_CTRL) c0_reg <= reg_wdata;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) pol_reg <= `CLF_RST_POLARITY;
        else if (reg_write && reg_addr == `CLF_ADDR_POLARITY) pol_reg <= reg_wdata;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_absent_forced;
        c0_reg[`CLF_C0_FORCE_ABSENT] && !c0_reg[`CLF_C0_FORCE_PRESENT];
    endsequence
    a_tf_polarity: assert property (|(~mask.term_fault & (detect.term_fault
        ^ pol_reg[`CLF_POL_TF_HI:`CLF_POL_TF_LO])) |=> !fault_n)
        else $error("term fault polarity ignored");
    a_status_polarity: assert property ((!mask.signal_status
        && (detect.signal_present == pol_reg[`CLF_POL_STATUS])) |=> !fault_n)
        else $error("signal status polarity ignored");
    a_enable_off_pd: assert property (!enable_pin |=> drive.power_down == 2'b11)
        else $error("enable low did not power down");
    a_pd_bit_down: assert property (out0_power_down |=> drive.power_down[0])
        else $error("pd bit ignored");
    a_present_pd_clear: assert property ((enable_pin && !out1_power_down && detect.signal_present)
        |=> !drive.power_down[1])
        else $error("power down without cause");
    a_rate_pin_slow: assert property (rate_pin_high |=> slow_rate_active)
        else $error("rate pin not forcing slow");
    a_rate_bit_sel: assert property (!rate_pin_high |=> slow_rate_active == $past(low_rate_select))
        else $error("rate bit not followed");
    a_mask_all_quiet: assert property ((&mask) |=> fault_n)
        else $error("masked sources drove fault");
    a_force_present_quiet: assert property (c0_reg[`CLF_C0_FORCE_PRESENT] |=> !drive.mute && !drive.offset)
        else $error("mute or offset while forced present");
    a_forced_loss: assert property (s_absent_forced |=> drive.mute == $past(c0_reg[`CLF_C0_MUTE_SELECT])
        && drive.offset == !$past(c0_reg[`CLF_C0_MUTE_SELECT]))
        else $error("forced loss not applied");
    a_loss_select: assert property ((!c0_reg[`CLF_C0_FORCE_PRESENT] && !detect.signal_present)
        |=> drive.mute != drive.offset)
        else $error("loss handling wrong");
endmodule // clf_cfg_monitor
bind clf_config_bank clf_cfg_monitor u_mon (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .detect(detect), .mask(mask),
    .low_rate_select(low_rate_select), .rate_pin_high(rate_pin_high), .enable_pin(enable_pin),
    .out0_power_down(out0_power_down), .out1_power_down(out1_power_down), .fault_n(fault_n),
    .drive(drive), .slow_rate_active(slow_rate_active));
`default_nettype wire

// [testbench/clf_host_model.sv]
// Purpose: management host issuing single-byte register accesses
// Assumes: strobes last one clock, driven at the falling edge
// Notes:   address and data are inverted when idle so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module clf_host_model (
    input  wire logic       clock,      // clock
    output var  logic [7:0] reg_addr,   // address
    output var  logic       reg_write,  // write strobe
    output var  logic [7:0] reg_wdata,  // write data
    output var  logic       reg_read,   // read strobe
    input  wire logic [7:0] reg_rdata   // read data
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
        reg_read = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
        v = d;
        if (a == 8'h03) v[5] = 1'b0;
        if (a == 8'h05) v[7] = 1'b0;
        if (a == 8'h07) v[5:3] = 3'b011;
        @(negedge clock);
        {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
        @(negedge clock);
        {reg_addr, reg_wdata, reg_write} = {~a, ~v, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        {reg_addr, reg_read} = {a, 1'b1};
        @(negedge clock);
        {reg_addr, reg_read} = {~a, 1'b0};
        d = reg_rdata;
    endtask
endmodule // clf_host_model
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: random and corner-case test of the configuration bank
// Assumes: host model drives the register port
// Notes:   expectations come from a shadow copy of the registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import clf_pkg::*;
    logic clock, resetn, low_rate_select, rate_pin_high, enable_pin, out0_power_down, out1_power_down;
    logic reg_write, reg_read, fault_n, slow_rate_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [4:0] out0_swing_code, out1_swing_code;
    clf_detect_type detect;
    clf_mask_type mask;
    clf_drive_type drive;
    clf_thresh_type term_thresh;
    logic [7:0] r [3:7];
    int n_errors = 0, check_count = 0, i, a, seed;
    always #5 clock = ~clock;
    clf_config_bank u_dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .detect(detect), .mask(mask),
        .low_rate_select(low_rate_select), .rate_pin_high(rate_pin_high), .enable_pin(enable_pin),
        .out0_power_down(out0_power_down), .out1_power_down(out1_power_down), .fault_n(fault_n),
        .term_thresh(term_thresh), .out0_swing_code(out0_swing_code), .out1_swing_code(out1_swing_code),
        .drive(drive), .slow_rate_active(slow_rate_active));
    clf_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_read(reg_read), .reg_rdata(reg_rdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] e_thr(input logic s);
        e_thr = s ? {r[5][2:0], r[3][6], r[7][2:0], r[7][6]} : {r[4][7:5], r[3][7], r[6][7:5], r[7][7]};
    endfunction
    function automatic logic e_flt();
        e_flt = ~(|(~mask.term_fault & (detect.term_fault ^ r[3][4:1]))
            | (~mask.signal_status & (detect.signal_present == r[3][0])));
    endfunction
    function automatic logic [3:0] e_drv();
        logic l, p;
        l = ~r[5][5] & (r[5][6] | ~detect.signal_present);
        p = ~enable_pin | (r[5][4] & ~detect.signal_present);
        e_drv = {l & r[5][3], l & ~r[5][3], p | out1_power_down, p | out0_power_down};
    endfunction
    task automatic check_outs;
        chk(8'(fault_n), 8'(e_flt()), "fault pin");
        chk(8'(slow_rate_active), 8'(low_rate_select | rate_pin_high), "rate");
        chk(term_thresh, e_thr(low_rate_select | rate_pin_high), "threshold");
        chk({out0_swing_code, out1_swing_code[4:2]}, {r[4][4:0], r[6][4:2]}, "swing");
        chk(8'(out1_swing_code[1:0]), 8'(r[6][1:0]), "swing low");
        chk(8'(drive), 8'(e_drv()), "drive");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #60000;
        n_errors++;
        complete_run;
    end
    initial begin
        {clock, resetn, detect, mask, low_rate_select, rate_pin_high} = '0;
        {enable_pin, out0_power_down, out1_power_down} = 3'b100;
        r = '{8'hc0, 8'h90, 8'h02, 8'h90, 8'hda};
        seed = $urandom(52);
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        check_outs;
        for (i = 3; i < 8; i++) begin
            u_host.rd(8'(i), v);
            chk(v, r[i], "reset value");
        end
        u_host.rd(8'h08, v);
        chk(v, 8'h00, "unmapped read");
        u_host.wr(8'h05, 8'h68, r[5]);
        detect = '0;
        @(negedge clock);
        check_outs;
        for (i = 0; i < 300; i++) begin
            a = 3 + $urandom % 5;
            u_host.wr(8'(a), 8'($urandom), r[a]);
            {detect, mask, low_rate_select, rate_pin_high, enable_pin, out0_power_down, out1_power_down} = 15'($urandom);
            @(negedge clock);
            check_outs;
            u_host.rd(8'(a), v);
            chk(v, r[a], "readback");
        end
        // mid-run reset must bring every register back to its default
        @(negedge clock);
        resetn = 1'b0;
        r = '{8'hc0, 8'h90, 8'h02, 8'h90, 8'hda};
        @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        check_outs;
        for (i = 3; i < 8; i++) begin
            u_host.rd(8'(i), v);
            chk(v, r[i], "value after second reset");
        end
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
